// ===== bench/lcd_cmd_and_scan_addressing_tb.sv
// Self-checking testbench for the LCD command decoder and scan generator
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, e); end end
module lcd_cmd_and_scan_addressing_tb;
  localparam logic [7:0] ID_CODE = 8'ha5; // Arbitrary identification value
  int err_total = 0, n_checks = 0;
  int qc [$];
  logic mclk = 1'b0, reset = 1'b1, cmd_wr = 1'b0, par_wr = 1'b0, rd_req = 1'b0;
  logic mem_access = 1'b0, scan_en = 1'b0, text_mode = 1'b0, dual_panel = 1'b0;
  logic mem_rd_valid, rd_valid, scan_rd, cg_two_bytes, pixel_scroll_flag, scroll_lock_flag;
  logic vsync_polarity, hsync_polarity, data_enable_polarity, pixel_clock_polarity;
  logic upscale_mode_bit, color_mode_select, interface_select, sync_pin_drive, clock_pin_drive;
  logic [1:0] cursor_dir = 2'h0, gdep = 2'h0, gray_depth, pll_vco_field;
  logic [2:0] pixel_scroll_amt;
  logic [3:0] char_rows = 4'h1, char_width_field = 4'h9, pll_output_divider, pll_input_divider;
  logic [3:0] pll_range_field, pll_multiplier;
  logic [4:0] pll_loop_setting;
  logic [5:0] data_pin_drive;
  logic [7:0] wr_data = 8'h00, rd_data, mem_rd_data, vsync_width, hsync_width;
  logic [7:0] row_byte_count = 8'h02, total_row_read_cycles = 8'h03, panel_lines = 8'h08;
  logic [10:0] tf [10]; // Timing fields in parameter order
  logic scan_panel, line_latch_pulse, hi;
  logic [7:0] char_code;
  int nl;
  logic [14:0] addr_pitch = 15'h0040, upper_start = 15'h0100, lower_start = 15'h2000;
  logic [14:0] cursor_addr, char_ram_base, scan_addr, cur, ea;
  logic [15:0][5:0] palette_entry_bit;
  logic [7:0] pb [23];
  logic [15:0] q [$];
  logic [7:0] cmds [10] = '{8'h60, 8'h5a, 8'h5c, 8'h46, 8'h62, 8'h63, 8'h64, 8'h65, 8'h67, 8'h68};
  int np [10] = '{1, 1, 2, 2, 3, 1, 22, 1, 16, 1};

  // 25 MHz clock
  always #20 mclk = ~mclk;

  lcd_cmd_scan #(.IDENT_CODE(ID_CODE)) i_lcd_cmd_scan (.mclk, .reset, .cmd_wr, .par_wr, .wr_data,
    .rd_req, .rd_data, .rd_valid, .mem_access, .cursor_dir, .cursor_addr, .char_ram_base,
    .pixel_scroll_flag, .pixel_scroll_amt, .gray_depth, .pll_output_divider, .pll_input_divider,
    .pll_range_field, .pll_multiplier, .pll_vco_field, .pll_loop_setting, .vsync_polarity,
    .hsync_polarity, .data_enable_polarity, .pixel_clock_polarity, .upscale_mode_bit,
    .color_mode_select, .interface_select, .horizontal_total(tf[0]),
    .horizontal_display_period(tf[1]), .horizontal_display_start(tf[2]), .vertical_total(tf[3]),
    .vertical_display_period(tf[4]), .vertical_display_start(tf[5]), .vsync_width, .hsync_width,
    .hsync_pulse_position(tf[6]), .horizontal_start_ref(tf[7]), .vertical_start_ref(tf[8]),
    .horizontal_output_offset(tf[9]), .scroll_lock_flag,
    .palette_entry_bit, .sync_pin_drive, .clock_pin_drive, .data_pin_drive, .scan_en, .text_mode,
    .dual_panel, .row_byte_count, .total_row_read_cycles, .addr_pitch, .char_rows, .panel_lines,
    .upper_start, .lower_start, .char_width_field, .scan_addr, .scan_rd, .scan_panel, .cg_row(),
    .cg_two_bytes, .line_latch_pulse, .mem_rd_valid, .mem_rd_data, .char_code, .pix_data(),
    .pix_color());

  scan_mem_model i_scan_mem_model (.mclk, .scan_rd, .scan_addr, .mem_rd_valid, .mem_rd_data);

  // Parameter byte i of command c as the decoded outputs show it
  function automatic logic [7:0] view(input logic [7:0] c, input int i);
    case (c)
      8'h5c: return i ? {1'b0, char_ram_base[14:8]} : char_ram_base[7:0];
      8'h46: return i ? {1'b0, cursor_addr[14:8]} : cursor_addr[7:0];
      8'h5a: return {pixel_scroll_flag, 4'h0, pixel_scroll_amt};
      8'h60: return {6'h00, gray_depth};
      8'h62: return i == 0 ? {pll_output_divider, pll_input_divider} : i == 1 ?
        {pll_range_field, pll_multiplier} : {1'b0, pll_vco_field, pll_loop_setting};
      8'h63: return {vsync_polarity, hsync_polarity, data_enable_polarity, pixel_clock_polarity,
        1'b0, upscale_mode_bit, color_mode_select, interface_select};
      8'h64: return i == 12 ? vsync_width : i == 13 ? hsync_width : i[0] ?
        {5'h00, tf[(i - 2 * (i > 13)) / 2][10:8]} : tf[(i - 2 * (i > 13)) / 2][7:0];
      8'h65: return {scroll_lock_flag, 7'h00};
      8'h67: return {2'h0, palette_entry_bit[i]};
      default: return {sync_pin_drive, clock_pin_drive, data_pin_drive};
    endcase
  endfunction : view

  // Legal bits of each parameter; reserved bits stay zero
  function automatic logic [7:0] mask(input logic [7:0] c, input int i);
    case (c)
      8'h5c, 8'h46: return i ? 8'h7f : 8'hff;
      8'h5a: return gdep != 2'h0 ? 8'h80 : 8'h87;
      8'h60: return 8'h03;
      8'h62: return i == 2 ? 8'h7f : 8'hff;
      8'h63: return 8'hf7;
      8'h64: return i[0] && (i < 12 || i > 13) ? 8'h07 : 8'hff;
      8'h65: return 8'h80;
      8'h67: return 8'h3f;
      default: return 8'hff;
    endcase
  endfunction : mask

  // Host byte write: command when c is high, else parameter; calls run back to back
  task automatic put(input logic c, input logic [7:0] d);
    @(negedge mclk);
    cmd_wr = c;
    par_wr = !c;
    wr_data = d;
  endtask : put

  // Drop the write strobes for one cycle
  task automatic idle();
    @(negedge mclk);
    cmd_wr = 1'b0;
    par_wr = 1'b0;
  endtask : idle

  // Host byte read, answer looked at in the cycle after the request
  task automatic get(input logic [7:0] e);
    @(negedge mclk);
    {cmd_wr, par_wr, rd_req} = 3'b001;
    @(negedge mclk);
    rd_req = 1'b0;
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask : get

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h19bc));
    addr_pitch = 15'h0010 + 15'($urandom() % 200);
    upper_start = 15'($urandom() % 4096);
    lower_start = 15'h4000 + 15'($urandom() % 4096);
    panel_lines = 8'h08 + 8'($urandom() % 8);
    repeat (16) @(posedge mclk);
    @(negedge mclk) reset = 1'b0;
    // Every parameter command, random legal bytes, then one surplus byte that must be ignored
    for (int rnd = 0; rnd < 3; rnd++) begin
      for (int k = 0; k < 10; k++) begin
        put(1'b1, cmds[k]);
        for (int i = 0; i < np[k]; i++) begin
          pb[i] = 8'($urandom()) & mask(cmds[k], i);
          if (cmds[k] == 8'h60 && pb[i] == 8'h03) pb[i] = 8'h02;
          put(1'b0, pb[i]);
        end
        if (cmds[k] == 8'h60) gdep = pb[0][1:0];
        if (cmds[k] == 8'h46) cur = {pb[1][6:0], pb[0]};
        put(1'b0, 8'($urandom()));
        idle();
        for (int i = 0; i < np[k]; i++)
          `CHK(view(cmds[k], i), pb[i])
      end
    end
    $display("test command fields done");
    put(1'b1, 8'h47);
    get(cur[7:0]);
    get({1'b0, cur[14:8]});
    put(1'b1, 8'h61);
    get(ID_CODE);
    $display("test host reads done");
    // Cursor stepping in all four directions
    for (int d = 0; d < 4; d++) begin
      @(negedge mclk);
      cursor_dir = d[1:0];
      mem_access = 1'b1;
      @(negedge mclk);
      mem_access = 1'b0;
      cur = d == 0 ? cur + 15'h1 : d == 1 ? cur - 15'h1 : d == 2 ? cur - addr_pitch : cur + addr_pitch;
      `CHK(cursor_addr, cur)
    end
    $display("test cursor step done");
    `CHK(cg_two_bytes, 1'b1)
    // Graphics, text, then dual-panel graphics with a longer pause
    for (int t = 0; t < 3; t++) begin
      text_mode = t == 1;
      dual_panel = t == 2;
      total_row_read_cycles = t == 2 ? 8'h05 : 8'h03;
      q = {};
      qc = {};
      nl = 0;
      scan_en = 1'b1;
      for (int c = 0; c < 60 && q.size() < 6; c++) begin
        @(negedge mclk);
        if (line_latch_pulse === 1'b1) nl++;
        if (scan_rd === 1'b1) q.push_back({scan_panel, scan_addr});
        if (scan_rd === 1'b1) qc.push_back(c);
      end
      scan_en = 1'b0;
      if (q.size() < 6) begin
        err_total++;
        $display("[FAIL] %0t scan stalled", $time);
        end_sim();
      end
      for (int j = 0; j < 6; j++) begin
        hi = t == 2 && j % 4 > 1;
        ea = 15'((hi ? lower_start : upper_start) + j % 2 + addr_pitch * (t ? j / 4 : j / 2));
        `CHK(q[j], {hi, ea})
      end
      `CHK(qc[2] - qc[1], t == 2 ? 4 : 2)
      `CHK(nl, t == 2 ? 1 : 2)
      repeat (12) @(negedge mclk);
    end
    // Last text byte read was the second one of the second text line
    `CHK(char_code, 8'(upper_start + addr_pitch + 1))
    $display("test scan done");
    end_sim();
  end
endmodule : lcd_cmd_and_scan_addressing_tb
`default_nettype wire

// ===== bench/scan_mem_model.sv
// Display memory model that answers the scan generator's reads
`timescale 1ns/1ns
`default_nettype none
module scan_mem_model (
  // Clock
  input wire logic mclk,
  // Read request from the scan generator
  input wire logic scan_rd,
  input wire logic [14:0] scan_addr,
  // Returned byte
  output logic mem_rd_valid,
  output logic [7:0] mem_rd_data
);
  // One cycle latency; an idle bus toggles so a stale byte never looks valid
  initial mem_rd_data = 8'h00;
  always @(posedge mclk) begin
    mem_rd_valid <= scan_rd;
    mem_rd_data <= scan_rd ? scan_addr[7:0] : ~mem_rd_data;
  end
endmodule : scan_mem_model
`default_nettype wire

// ===== rtl/lcd_cmd_pkg.sv
// Constants shared by the LCD command decoder and display scan generator
package lcd_cmd_pkg;
  // ----------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CGRAM_BASE = 8'h5c;
  localparam logic [7:0] CMD_PIX_SCROLL = 8'h5a;
  localparam logic [7:0] CMD_CSR_WRITE = 8'h46;
  localparam logic [7:0] CMD_CSR_READ = 8'h47;
  localparam logic [7:0] CMD_GRAY = 8'h60;
  localparam logic [7:0] CMD_IDENT = 8'h61;
  localparam logic [7:0] CMD_PLL = 8'h62;
  localparam logic [7:0] CMD_POLARITY = 8'h63;
  localparam logic [7:0] CMD_TIMING = 8'h64;
  localparam logic [7:0] CMD_SCROLL_LOCK = 8'h65;
  localparam logic [7:0] CMD_PALETTE = 8'h67;
  localparam logic [7:0] CMD_PIN_DRIVE = 8'h68;
  // ----------------------------------------------------------------
  // Parameter counts and timing-table layout
  // ----------------------------------------------------------------
  localparam logic [4:0] NPAR_PLL = 5'h03;
  localparam logic [4:0] NPAR_TIMING = 5'h16;
  localparam logic [4:0] NPAR_PALETTE = 5'h10;
  localparam logic [4:0] TIM_WIDTH_IDX_VS = 5'h0c; // Vertical sync width byte
  localparam logic [4:0] TIM_WIDTH_IDX_HS = 5'h0d; // Horizontal sync width byte
  localparam logic [4:0] TIM_SECOND_GROUP = 5'h0e; // First index of the late 11-bit group
  localparam int TIM_FIELDS = 10;
  // ----------------------------------------------------------------
  // Gray depth codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] DEPTH_1BPP = 2'h0;
  localparam logic [1:0] DEPTH_2BPP = 2'h1;
  localparam logic [1:0] DEPTH_4BPP = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [14:0] RST_ADDR = 15'h0000;
  // Cursor step directions
  localparam logic [1:0] DIR_RIGHT = 2'h0;
  localparam logic [1:0] DIR_LEFT = 2'h1;
  localparam logic [1:0] DIR_UP = 2'h2;
  localparam logic [1:0] DIR_DOWN = 2'h3;
endpackage : lcd_cmd_pkg

// ===== rtl/lcd_cmd_scan.sv
// LCD controller command decoder and display memory scan address generator
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Char RAM base command: low address byte, then high byte holding bits 14-8
// - Pixel scroll command: bit 7 enable flag, bits 2-0 scroll amount
// - Cursor write/read: low byte then high byte, high holds bits 14-8
// - Gray depth command: bits 1-0 select bits per pixel
// - After identification command the next read returns the ID byte
// - PLL command: three bytes of dividers, multiplier, field and loop setting
// - Polarity command: four polarities, then upscale, color mode, interface select
// - Timing command: 22 bytes, 11-bit pairs low first, two 8-bit widths
// - Scroll lock command: bit 7 is the scroll synchronisation flag
// - Palette command: sixteen 6-bit entries in order 0 to 15
// - Pin drive command: sync, pixel clock and six data pin strengths
// - First bitmap bit is top-left; next bits are right neighbours
// - Character width up to 16; two bitmap bytes per row above eight
// - Rows read left to right for row-byte count, rows top to bottom
// - Graphics: each line starts at previous line start plus pitch
// - Text: same start per bitmap row, add pitch after last row
// - Byte is one character in text, 8/4/2 pixels at 1/2/4 bpp
// - Dual panel: upper and lower lines fetched alternately, one line each
// - Idle total-row minus row-byte read cycles at each line end
// - Dual panel: latch pulse only after lower screen; idle on both
// - Color mode select 0 gray scale, 1 palette of sixteen entries
// - Each memory access steps the cursor by the direction setting unless a host cursor write comes in the same cycle
module lcd_cmd_scan #(
  parameter logic [7:0] IDENT_CODE = 8'h3c // Arbitrary identification value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host byte port
  input wire logic cmd_wr,
  input wire logic par_wr,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Cursor stepping
  input wire logic mem_access,
  input wire logic [1:0] cursor_dir,
  output logic [14:0] cursor_addr,
  // Decoded configuration
  output logic [14:0] char_ram_base,
  output logic pixel_scroll_flag,
  output logic [2:0] pixel_scroll_amt,
  output logic [1:0] gray_depth,
  output logic [3:0] pll_output_divider,
  output logic [3:0] pll_input_divider,
  output logic [3:0] pll_range_field,
  output logic [3:0] pll_multiplier,
  output logic [1:0] pll_vco_field,
  output logic [4:0] pll_loop_setting,
  output logic vsync_polarity,
  output logic hsync_polarity,
  output logic data_enable_polarity,
  output logic pixel_clock_polarity,
  output logic upscale_mode_bit,
  output logic color_mode_select,
  output logic interface_select,
  output logic [10:0] horizontal_total,
  output logic [10:0] horizontal_display_period,
  output logic [10:0] horizontal_display_start,
  output logic [10:0] vertical_total,
  output logic [10:0] vertical_display_period,
  output logic [10:0] vertical_display_start,
  output logic [7:0] vsync_width,
  output logic [7:0] hsync_width,
  output logic [10:0] hsync_pulse_position,
  output logic [10:0] horizontal_start_ref,
  output logic [10:0] vertical_start_ref,
  output logic [10:0] horizontal_output_offset,
  output logic scroll_lock_flag,
  output logic [15:0][5:0] palette_entry_bit,
  output logic sync_pin_drive,
  output logic clock_pin_drive,
  output logic [5:0] data_pin_drive,
  // Scan configuration
  input wire logic scan_en,
  input wire logic text_mode,
  input wire logic dual_panel,
  input wire logic [7:0] row_byte_count,
  input wire logic [7:0] total_row_read_cycles,
  input wire logic [14:0] addr_pitch,
  input wire logic [3:0] char_rows,
  input wire logic [7:0] panel_lines,
  input wire logic [14:0] upper_start,
  input wire logic [14:0] lower_start,
  input wire logic [3:0] char_width_field,
  // Scan outputs
  output logic [14:0] scan_addr,
  output logic scan_rd,
  output logic scan_panel,
  output logic [3:0] cg_row,
  output logic cg_two_bytes,
  output logic line_latch_pulse,
  // Fetched byte to pixels
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_rd_data,
  output logic [7:0] char_code,
  output logic [3:0] pix_data,
  output logic [5:0] pix_color
);
  // ----------------------------------------------------------------
  // Command decoder
  // ----------------------------------------------------------------
  logic [7:0] cmd_q;
  logic [4:0] idx_q;
  logic [10:0] tim_q [lcd_cmd_pkg::TIM_FIELDS];
  logic [3:0] tim_sel;

  // Timing byte to field: low group pairs, two widths, late group pairs
  always_comb begin
    if (idx_q < lcd_cmd_pkg::TIM_WIDTH_IDX_VS) begin
      tim_sel = idx_q[4:1];
    end else begin
      tim_sel = 4'(5'(idx_q - lcd_cmd_pkg::TIM_SECOND_GROUP) >> 1) + 4'h6;
    end
  end

  // Parameter counter restarts on each command byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_q <= lcd_cmd_pkg::RST_BYTE;
      idx_q <= 5'h00;
    end else if (cmd_wr) begin
      cmd_q <= wr_data;
      idx_q <= 5'h00;
    end else if ((par_wr || rd_req) && idx_q != 5'h1f) begin
      idx_q <= idx_q + 5'h01;
    end
  end

  // Single-byte and short multi-byte settings
  always_ff @(posedge mclk) begin
    if (reset) begin
      char_ram_base <= lcd_cmd_pkg::RST_ADDR;
      {pixel_scroll_flag, pixel_scroll_amt} <= 4'h0;
      gray_depth <= lcd_cmd_pkg::DEPTH_1BPP;
      {pll_output_divider, pll_input_divider} <= lcd_cmd_pkg::RST_BYTE;
      {pll_range_field, pll_multiplier} <= lcd_cmd_pkg::RST_BYTE;
      {pll_vco_field, pll_loop_setting} <= 7'h00;
      {vsync_polarity, hsync_polarity, data_enable_polarity, pixel_clock_polarity} <= 4'h0;
      {upscale_mode_bit, color_mode_select, interface_select} <= 3'h0;
      scroll_lock_flag <= 1'b0;
      {sync_pin_drive, clock_pin_drive, data_pin_drive} <= lcd_cmd_pkg::RST_BYTE;
    end else if (par_wr) begin
      case (cmd_q)
        lcd_cmd_pkg::CMD_CGRAM_BASE: begin
          if (idx_q == 5'h00) char_ram_base[7:0] <= wr_data;
          if (idx_q == 5'h01) char_ram_base[14:8] <= wr_data[6:0];
        end
        lcd_cmd_pkg::CMD_PIX_SCROLL: begin
          if (idx_q == 5'h00) begin
            pixel_scroll_flag <= wr_data[7];
            pixel_scroll_amt <= wr_data[2:0];
          end
        end
        lcd_cmd_pkg::CMD_GRAY: begin
          if (idx_q == 5'h00) gray_depth <= wr_data[1:0];
        end
        lcd_cmd_pkg::CMD_PLL: begin
          if (idx_q == 5'h00) {pll_output_divider, pll_input_divider} <= wr_data;
          if (idx_q == 5'h01) {pll_range_field, pll_multiplier} <= wr_data;
          if (idx_q == 5'h02) {pll_vco_field, pll_loop_setting} <= wr_data[6:0];
        end
        lcd_cmd_pkg::CMD_POLARITY: begin
          if (idx_q == 5'h00) begin
            {vsync_polarity, hsync_polarity} <= wr_data[7:6];
            {data_enable_polarity, pixel_clock_polarity} <= wr_data[5:4];
            {upscale_mode_bit, color_mode_select, interface_select} <= wr_data[2:0];
          end
        end
        lcd_cmd_pkg::CMD_SCROLL_LOCK: begin
          if (idx_q == 5'h00) scroll_lock_flag <= wr_data[7];
        end
        lcd_cmd_pkg::CMD_PIN_DRIVE: begin
          if (idx_q == 5'h00) begin
            {sync_pin_drive, clock_pin_drive, data_pin_drive} <= wr_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Panel timing table; bytes past the count are dropped
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < lcd_cmd_pkg::TIM_FIELDS; i++) tim_q[i] <= 11'h000;
      vsync_width <= lcd_cmd_pkg::RST_BYTE;
      hsync_width <= lcd_cmd_pkg::RST_BYTE;
    end else if (par_wr && cmd_q == lcd_cmd_pkg::CMD_TIMING
                 && idx_q < lcd_cmd_pkg::NPAR_TIMING) begin
      if (idx_q == lcd_cmd_pkg::TIM_WIDTH_IDX_VS) begin
        vsync_width <= wr_data;
      end else if (idx_q == lcd_cmd_pkg::TIM_WIDTH_IDX_HS) begin
        hsync_width <= wr_data;
      end else if (idx_q[0]) begin
        tim_q[tim_sel][10:8] <= wr_data[2:0];
      end else begin
        tim_q[tim_sel][7:0] <= wr_data;
      end
    end
  end

  assign horizontal_total = tim_q[0];
  assign horizontal_display_period = tim_q[1];
  assign horizontal_display_start = tim_q[2];
  assign vertical_total = tim_q[3];
  assign vertical_display_period = tim_q[4];
  assign vertical_display_start = tim_q[5];
  assign hsync_pulse_position = tim_q[6];
  assign horizontal_start_ref = tim_q[7];
  assign vertical_start_ref = tim_q[8];
  assign horizontal_output_offset = tim_q[9];

  // Palette entries fill in order 0 to 15
  always_ff @(posedge mclk) begin
    if (reset) begin
      palette_entry_bit <= '0;
    end else if (par_wr && cmd_q == lcd_cmd_pkg::CMD_PALETTE
                 && idx_q < lcd_cmd_pkg::NPAR_PALETTE) begin
      palette_entry_bit[idx_q[3:0]] <= wr_data[5:0];
    end
  end

  // Cursor: host write wins over a simultaneous memory-access step
  always_ff @(posedge mclk) begin
    if (reset) begin
      cursor_addr <= lcd_cmd_pkg::RST_ADDR;
    end else if (par_wr && cmd_q == lcd_cmd_pkg::CMD_CSR_WRITE && idx_q == 5'h00) begin
      cursor_addr[7:0] <= wr_data;
    end else if (par_wr && cmd_q == lcd_cmd_pkg::CMD_CSR_WRITE && idx_q == 5'h01) begin
      cursor_addr[14:8] <= wr_data[6:0];
    end else if (mem_access) begin
      case (cursor_dir)
        lcd_cmd_pkg::DIR_RIGHT: cursor_addr <= cursor_addr + 15'h0001;
        lcd_cmd_pkg::DIR_LEFT: cursor_addr <= cursor_addr - 15'h0001;
        lcd_cmd_pkg::DIR_UP: cursor_addr <= cursor_addr - addr_pitch;
        default: cursor_addr <= cursor_addr + addr_pitch;
      endcase
    end
  end

  // Read answers one cycle after the request
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data <= lcd_cmd_pkg::RST_BYTE;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        if (cmd_q == lcd_cmd_pkg::CMD_IDENT) rd_data <= IDENT_CODE;
        else if (cmd_q == lcd_cmd_pkg::CMD_CSR_READ && idx_q == 5'h00)
          rd_data <= cursor_addr[7:0];
        else if (cmd_q == lcd_cmd_pkg::CMD_CSR_READ && idx_q == 5'h01)
          rd_data <= {1'b0, cursor_addr[14:8]};
        else rd_data <= lcd_cmd_pkg::RST_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Display scan generator
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_PAUSE = 3'b100
  } scan_state_e;

  scan_state_e st_q;
  logic [7:0] col_q;
  logic [7:0] pause_cnt_q;
  logic [7:0] line_q;
  logic [14:0] start_q [2];
  logic [7:0] pause_len;
  logic last_col;
  logic row_done;
  logic bump_start;

  // A short total simply means no pause rather than a huge wrap-around
  assign pause_len = (total_row_read_cycles > row_byte_count)
                     ? 8'(total_row_read_cycles - row_byte_count) : 8'h00;
  assign last_col = (col_q + 8'h01 >= row_byte_count);
  assign row_done = (st_q == ST_READ && last_col && pause_len == 8'h00)
                    || (st_q == ST_PAUSE && pause_cnt_q >= pause_len);
  assign bump_start = !text_mode || (cg_row == char_rows);
  assign scan_rd = (st_q == ST_READ);
  assign cg_two_bytes = (char_width_field > 4'h7);

  // Row walk, per-panel pause and line advance
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= ST_IDLE;
      col_q <= 8'h00;
      pause_cnt_q <= 8'h00;
      line_q <= 8'h00;
      scan_panel <= 1'b0;
      cg_row <= 4'h0;
      scan_addr <= lcd_cmd_pkg::RST_ADDR;
      start_q[0] <= lcd_cmd_pkg::RST_ADDR;
      start_q[1] <= lcd_cmd_pkg::RST_ADDR;
      line_latch_pulse <= 1'b0;
    end else begin
      line_latch_pulse <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (scan_en) begin
            st_q <= ST_READ;
            start_q[0] <= upper_start;
            start_q[1] <= lower_start;
            scan_addr <= upper_start;
            {col_q, line_q, cg_row, scan_panel} <= '0;
          end
        end
        ST_READ, ST_PAUSE: begin
          if (st_q == ST_READ) begin
            scan_addr <= scan_addr + 15'h0001;
            col_q <= col_q + 8'h01;
            if (last_col) begin
              st_q <= ST_PAUSE;
              pause_cnt_q <= 8'h01;
            end
          end else begin
            pause_cnt_q <= pause_cnt_q + 8'h01;
          end
          if (row_done) begin
            col_q <= 8'h00;
            st_q <= scan_en ? ST_READ : ST_IDLE;
            if (dual_panel && !scan_panel) begin
              scan_panel <= 1'b1;
              scan_addr <= start_q[1];
            end else begin
              line_latch_pulse <= 1'b1;
              scan_panel <= 1'b0;
              cg_row <= (text_mode && cg_row != char_rows) ? cg_row + 4'h1 : 4'h0;
              if (line_q + 8'h01 >= panel_lines) begin
                line_q <= 8'h00;
                cg_row <= 4'h0;
                start_q[0] <= upper_start;
                start_q[1] <= lower_start;
                scan_addr <= upper_start;
              end else begin
                line_q <= line_q + 8'h01;
                start_q[0] <= bump_start ? start_q[0] + addr_pitch : start_q[0];
                start_q[1] <= bump_start ? start_q[1] + addr_pitch : start_q[1];
                scan_addr <= bump_start ? start_q[0] + addr_pitch : start_q[0];
              end
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fetched byte to character code or pixels, leftmost from the top bit
  // ----------------------------------------------------------------
  logic [7:0] pix_sr_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pix_sr_q <= lcd_cmd_pkg::RST_BYTE;
      char_code <= lcd_cmd_pkg::RST_BYTE;
    end else if (mem_rd_valid) begin
      if (text_mode) char_code <= mem_rd_data;
      else pix_sr_q <= mem_rd_data;
    end else begin
      case (gray_depth)
        lcd_cmd_pkg::DEPTH_2BPP: pix_sr_q <= {pix_sr_q[5:0], 2'h0};
        lcd_cmd_pkg::DEPTH_4BPP: pix_sr_q <= {pix_sr_q[3:0], 4'h0};
        default: pix_sr_q <= {pix_sr_q[6:0], 1'b0};
      endcase
    end
  end

  // Pixel value in the low bits; palette lookup only in palette mode
  always_comb begin
    case (gray_depth)
      lcd_cmd_pkg::DEPTH_2BPP: pix_data = {2'h0, pix_sr_q[7:6]};
      lcd_cmd_pkg::DEPTH_4BPP: pix_data = pix_sr_q[7:4];
      default: pix_data = {3'h0, pix_sr_q[7]};
    endcase
    pix_color = color_mode_select ? palette_entry_bit[pix_data] : {pix_data, 2'h0};
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_cursor_write_command_pair;
    cmd_wr && wr_data == lcd_cmd_pkg::CMD_CSR_WRITE ##1 par_wr && !cmd_wr ##1 par_wr && !cmd_wr;
  endsequence

  a_cursor_write: assert property (s_cursor_write_command_pair |=> cursor_addr[14:8] == $past(wr_data[6:0])
    && cursor_addr[7:0] == $past(wr_data, 2)) else $error("cursor write bytes lost");
  a_ident_read: assert property (cmd_wr && wr_data == lcd_cmd_pkg::CMD_IDENT ##1
    rd_req && !cmd_wr |=> rd_valid && rd_data == IDENT_CODE) else $error("id byte wrong");
  a_cgram_high: assert property (par_wr && cmd_q == lcd_cmd_pkg::CMD_CGRAM_BASE
    && idx_q == 5'h01 |=> char_ram_base[14:8] == $past(wr_data[6:0])) else $error("cg base high");
  a_gray_depth: assert property (par_wr && cmd_q == lcd_cmd_pkg::CMD_GRAY && idx_q == 5'h00
    |=> gray_depth == $past(wr_data[1:0])) else $error("gray depth not stored");
  a_param_count: assert property (par_wr && !cmd_wr && idx_q < 5'h1e
    |=> idx_q == $past(idx_q) + 5'h01) else $error("param index stuck");
  a_cursor_step: assert property (mem_access && !par_wr && cursor_dir == lcd_cmd_pkg::DIR_RIGHT
    |=> cursor_addr == $past(cursor_addr) + 15'h0001) else $error("cursor step wrong");
  a_latch_lower: assert property (line_latch_pulse && $past(dual_panel)
    |-> $past(scan_panel)) else $error("latch after upper panel");
  a_pause_len: assert property (st_q == ST_READ && last_col && pause_len == 8'h03 && scan_en
    && $stable(pause_len) |=> st_q == ST_PAUSE [*3] ##1 st_q == ST_READ) else $error("pause length");
  a_row_ltor: assert property (st_q == ST_READ && !last_col
    |=> scan_addr == $past(scan_addr) + 15'h0001) else $error("row not left to right");
  a_graph_line: assert property (row_done && !text_mode && !dual_panel && line_q + 8'h01 < panel_lines
    |=> scan_addr == $past(start_q[0]) + $past(addr_pitch)) else $error("graphics line start");
endmodule : lcd_cmd_scan
`default_nettype wire
